// ===== rtl/imps_sequencer.sv
// Purpose: Event-driven protocol sequencer for an I2C master controller that can lose arbitration to other masters.
// Assumes: Engine events are spaced by at least a byte time; commands likewise.
// Notes:   Host requests and engine events share one transition table.
`default_nettype none

//Function
// - Eight protocol states coded zero to seven.
// - Ten events coded zero to nine recognised.
// - Host requests and interrupts share one table.
// - Meaningless event: state kept, other-error returned.
// - Uninitialized takes init; idle takes start only.
// - Start-wait sends or resends address, direction waits.
// - Address done selects send, receive or stop.
// - Send done sends next byte, returns to start-wait for a read, or stops.
// - Receive done stores byte, continues or ends.
// - Stop detected terminates and releases channel.
// - Lost arbitration and NACK handled in busy states.
// - Channel flag blocks start while communicating.
// - Channel flags kept independently per channel.
// - Each device keeps its own state flag.
// - Done events timed on ninth/eighth clock fall.
// - Acknowledge each byte except the last one.
module imps_sequencer
  import imps_pkg::*;
#(
  parameter  int unsigned NUM_CH  = 2,
  parameter  int unsigned NUM_DEV = 4,
  localparam int unsigned CHW     = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
  localparam int unsigned DVW     = (NUM_DEV > 1) ? $clog2(NUM_DEV) : 1
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    link_clk,
  input  wire logic                    req_valid,
  input  wire logic [3:0]              req_event,
  input  wire logic [CHW-1:0]          req_chan,
  input  wire logic [DVW-1:0]          req_dev,
  input  wire logic [IMPS_BYTE_W-1:0]  req_data,
  input  wire logic [IMPS_LEN_W-1:0]   req_tx_len,
  input  wire logic [IMPS_LEN_W-1:0]   req_rx_len,
  output logic                         req_ready,
  output logic                         res_valid,
  output imps_res_t                    res_code,
  input  wire logic                    tx_valid,
  input  wire logic [IMPS_BYTE_W-1:0]  tx_data,
  output logic                         tx_ready,
  output logic                         rx_valid,
  output logic [IMPS_BYTE_W-1:0]       rx_data,
  input  wire logic                    rx_ready,
  output logic [2*NUM_CH-1:0]          channel_state_flag,
  output logic [2*NUM_DEV-1:0]         device_state_flag,
  output imps_state_t                  seq_state,
  input  wire logic                    eng_evt_valid,
  input  wire logic [3:0]              eng_evt_code,
  input  wire logic [IMPS_BYTE_W-1:0]  eng_evt_data,
  output logic                         eng_cmd_valid,
  output imps_cmd_t                    eng_cmd_code,
  output logic [IMPS_BYTE_W-1:0]       eng_cmd_data,
  output logic                         eng_cmd_ack
);

  typedef struct packed {
    imps_state_t                 state;
    imps_flag_t [NUM_CH-1:0]     ch_flag;
    imps_flag_t [NUM_DEV-1:0]    dev_flag;
    logic [CHW-1:0]              cur_ch;
    logic [DVW-1:0]              cur_dev;
    logic [IMPS_LEN_W-1:0]       tx_rem;
    logic [IMPS_LEN_W-1:0]       rx_rem;
    logic                        nack_seen;
    logic                        need_tx;
    logic                        hreq_v;
    logic [3:0]                  hreq_evt;
    logic [CHW-1:0]              hreq_ch;
    logic [DVW-1:0]              hreq_dev;
    logic [IMPS_BYTE_W-1:0]      hreq_data;
    logic [IMPS_LEN_W-1:0]       hreq_tx;
    logic [IMPS_LEN_W-1:0]       hreq_rx;
    logic                        req_ready;
    logic                        levt_v;
    logic [3:0]                  levt_code;
    logic [IMPS_BYTE_W-1:0]      levt_data;
    logic                        es1;
    logic                        es2;
    logic                        es3;
    logic                        cmd_tog;
    imps_cmd_t                   cmd_code;
    logic [IMPS_BYTE_W-1:0]      cmd_data;
    logic                        cmd_ack;
    logic                        res_v;
    imps_res_t                   res_code;
    logic                        head_v;
    logic                        tail_v;
    logic [IMPS_BYTE_W-1:0]      head_d;
    logic [IMPS_BYTE_W-1:0]      tail_d;
  } imps_sys_t;

  typedef struct packed {
    logic                        cs1;
    logic                        cs2;
    logic                        cs3;
    logic                        evt_tog;
    logic [3:0]                  evt_code;
    logic [IMPS_BYTE_W-1:0]      evt_data;
    logic                        cmd_v;
    imps_cmd_t                   cmd_code;
    logic [IMPS_BYTE_W-1:0]      cmd_data;
    logic                        cmd_ack;
  } imps_link_t;

  imps_sys_t   q;
  imps_sys_t   n;
  imps_link_t  l_q;
  imps_link_t  l_n;
  logic        tx_fire;
  logic        lk_go;
  logic        hs_go;
  logic        disp_v;
  imps_event_t disp_evt;

  // Which events carry meaning in which state; anything else is an error.
  function automatic logic legal(input imps_state_t s, input imps_event_t e);
    logic busy_err;
    busy_err = (e == event_arb_lost) || (e == event_nack);
    unique case (s)
      state_uninitialized:   legal = (e == event_init);
      state_idle:            legal = (e == event_start);
      state_start_wait:      legal = (e == event_addr) || (e == event_readdr);
      state_write_addr_wait,
      state_read_addr_wait:  legal = (e == event_addr_done) || busy_err;
      state_send_wait:       legal = (e == event_send_done) || busy_err;
      state_receive_wait:    legal = (e == event_receive_done) || busy_err;
      state_stop_wait:       legal = (e == event_stop) || busy_err;
    endcase
  endfunction : legal

  // One event per cycle: engine reports first, then host requests. A byte taken
  // from the send stream holds both back, so two commands never meet in a cycle.
  // A receive report waits while the buffer is full, which stalls the engine side.
  assign tx_fire  = q.need_tx & tx_valid;
  assign lk_go    = q.levt_v & ~tx_fire &
                    ~((q.levt_code == 4'(event_receive_done)) & q.tail_v);
  assign hs_go    = q.hreq_v & ~tx_fire & ~lk_go;
  assign disp_v   = lk_go | hs_go;
  assign disp_evt = lk_go ? imps_event_t'(q.levt_code) : imps_event_t'(q.hreq_evt);

  // Next state of the system-clock side.
  always_comb begin
    logic                   cmd_go;
    imps_cmd_t              cmd_c;
    logic [IMPS_BYTE_W-1:0] cmd_dat;
    logic                   cmd_a;
    logic                   push;
    cmd_go  = 1'b0;
    cmd_c   = cmd_stop;
    cmd_dat = '0;
    cmd_a   = 1'b0;
    push    = 1'b0;
    n       = q;
    n.res_v = 1'b0;
    // Receive buffer drain; the head register drives the outputs directly.
    if (q.head_v && rx_ready) begin
      n.head_v = q.tail_v;
      n.head_d = q.tail_d;
      n.tail_v = 1'b0;
    end
    if (req_valid && q.req_ready) begin
      n.hreq_v    = 1'b1;
      n.hreq_evt  = req_event;
      n.hreq_ch   = req_chan;
      n.hreq_dev  = req_dev;
      n.hreq_data = req_data;
      n.hreq_tx   = req_tx_len;
      n.hreq_rx   = req_rx_len;
    end
    if (tx_fire) begin
      n.need_tx = 1'b0;
      n.tx_rem  = q.tx_rem - IMPS_LEN_ONE;
      cmd_go    = 1'b1;
      cmd_c     = cmd_send;
      cmd_dat   = tx_data;
    end
    if (lk_go) n.levt_v = 1'b0;
    if (hs_go) n.hreq_v = 1'b0;
    if (disp_v) begin
      n.res_code = res_ok;
      if (!legal(q.state, disp_evt)) begin
        n.res_v    = 1'b1;
        n.res_code = res_err_other;
      end else begin
        unique case (disp_evt)
          event_init: begin
            n.ch_flag  = '0;
            n.dev_flag = '0;
            n.state    = state_idle;
            n.res_v    = 1'b1;
          end
          event_start: begin
            n.res_v = 1'b1;
            if (q.ch_flag[q.hreq_ch] == flag_comm) begin
              n.res_code = res_busy;
            end else begin
              n.ch_flag[q.hreq_ch]   = flag_comm;
              n.dev_flag[q.hreq_dev] = flag_comm;
              n.cur_ch    = q.hreq_ch;
              n.cur_dev   = q.hreq_dev;
              n.tx_rem    = q.hreq_tx;
              n.rx_rem    = q.hreq_rx;
              n.nack_seen = 1'b0;
              n.state     = state_start_wait;
              cmd_go      = 1'b1;
              cmd_c       = cmd_start;
            end
          end
          event_addr, event_readdr: begin
            cmd_go  = 1'b1;
            cmd_c   = (disp_evt == event_addr) ? cmd_addr : cmd_readdr;
            cmd_dat = q.hreq_data;
            n.state = q.hreq_data[IMPS_DIR_BIT] ? state_read_addr_wait
                                                 : state_write_addr_wait;
            n.res_v = 1'b1;
          end
          event_addr_done: begin
            // Pattern follows from the direction and the lengths: write, read, or address only.
            if (q.state == state_write_addr_wait && q.tx_rem != IMPS_LEN_ZERO) begin
              n.state   = state_send_wait;
              n.need_tx = 1'b1;
            end else if (q.state == state_read_addr_wait && q.rx_rem != IMPS_LEN_ZERO) begin
              n.state = state_receive_wait;
              cmd_go  = 1'b1;
              cmd_c   = cmd_receive;
              cmd_a   = (q.rx_rem > IMPS_LEN_ONE);
            end else begin
              n.state = state_stop_wait;
              cmd_go  = 1'b1;
            end
          end
          event_send_done: begin
            if (q.tx_rem != IMPS_LEN_ZERO) begin
              n.need_tx = 1'b1;
            end else if (q.rx_rem != IMPS_LEN_ZERO) begin
              n.state    = state_start_wait;
              n.res_v    = 1'b1;
              n.res_code = res_turn;
            end else begin
              n.state = state_stop_wait;
              cmd_go  = 1'b1;
            end
          end
          event_receive_done: begin
            push     = 1'b1;
            n.rx_rem = q.rx_rem - IMPS_LEN_ONE;
            cmd_go   = 1'b1;
            if (q.rx_rem > IMPS_LEN_ONE) begin
              cmd_c = cmd_receive;
              cmd_a = (q.rx_rem > IMPS_LEN_TWO);
            end else begin
              n.state = state_stop_wait;
            end
          end
          event_stop: begin
            n.ch_flag[q.cur_ch]   = q.nack_seen ? flag_nack : flag_finished;
            n.dev_flag[q.cur_dev] = q.nack_seen ? flag_nack : flag_finished;
            n.state    = state_idle;
            n.res_v    = 1'b1;
            n.res_code = q.nack_seen ? res_nack : res_done;
          end
          event_arb_lost: begin
            // The bus belongs to another master now, so no stop is generated.
            n.ch_flag[q.cur_ch]   = flag_idle;
            n.dev_flag[q.cur_dev] = flag_idle;
            n.need_tx  = 1'b0;
            n.state    = state_idle;
            n.res_v    = 1'b1;
            n.res_code = res_arb_lost;
          end
          event_nack: begin
            n.nack_seen = 1'b1;
            n.need_tx   = 1'b0;
            n.state     = state_stop_wait;
            cmd_go      = 1'b1;
          end
          default: ;
        endcase
      end
    end
    // timing belongs to the engine; the acknowledge bit rides with the
    // receive command so it is settled long before the ninth clock.
    if (push) begin
      if (!n.head_v) begin
        n.head_v = 1'b1;
        n.head_d = q.levt_data;
      end else begin
        n.tail_v = 1'b1;
        n.tail_d = q.levt_data;
      end
    end
    if (cmd_go) begin
      n.cmd_tog  = ~q.cmd_tog;
      n.cmd_code = cmd_c;
      n.cmd_data = cmd_dat;
      n.cmd_ack  = cmd_a;
    end
    // Engine event toggle crossing; the code and data are stable by then.
    n.es1 = l_q.evt_tog;
    n.es2 = q.es1;
    n.es3 = q.es2;
    if (q.es2 ^ q.es3) begin
      n.levt_v    = 1'b1;
      n.levt_code = l_q.evt_code;
      n.levt_data = l_q.evt_data;
    end
    n.req_ready = ~n.hreq_v;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else        q <= n;
  end

  // Link side: turns engine pulses into a toggle, and command toggles into pulses.
  always_comb begin
    l_n       = l_q;
    l_n.cs1   = q.cmd_tog;
    l_n.cs2   = l_q.cs1;
    l_n.cs3   = l_q.cs2;
    l_n.cmd_v = l_q.cs2 ^ l_q.cs3;
    if (l_q.cs2 ^ l_q.cs3) begin
      l_n.cmd_code = q.cmd_code;
      l_n.cmd_data = q.cmd_data;
      l_n.cmd_ack  = q.cmd_ack;
    end
    if (eng_evt_valid) begin
      l_n.evt_tog  = ~l_q.evt_tog;
      l_n.evt_code = eng_evt_code;
      l_n.evt_data = eng_evt_data;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) l_q <= '0;
    else        l_q <= l_n;
  end

  assign req_ready          = q.req_ready;
  assign res_valid          = q.res_v;
  assign res_code           = q.res_code;
  assign tx_ready           = q.need_tx;
  assign rx_valid           = q.head_v;
  assign rx_data            = q.head_d;
  assign channel_state_flag = q.ch_flag;
  assign device_state_flag  = q.dev_flag;
  assign seq_state          = q.state;
  assign eng_cmd_valid      = l_q.cmd_v;
  assign eng_cmd_code       = l_q.cmd_code;
  assign eng_cmd_data       = l_q.cmd_data;
  assign eng_cmd_ack        = l_q.cmd_ack;

  // Checks on the system-clock side.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_go(imps_state_t s, imps_event_t e);
    disp_v && legal(q.state, disp_evt) && q.state == s && disp_evt == e;
  endsequence
  sequence s_rx_last;
    s_go(state_receive_wait, event_receive_done) ##0 q.rx_rem == IMPS_LEN_TWO;
  endsequence

  a_illegal_event: assert property (disp_v && !legal(q.state, disp_evt) |=>
    q.res_v && q.res_code == res_err_other && q.state == $past(q.state))
    else $error("illegal event changed state or gave wrong result");
  a_init_idle: assert property (s_go(state_uninitialized, event_init) |=>
    q.state == state_idle && q.res_v && q.ch_flag == '0)
    else $error("init did not reach idle");
  a_start_launch: assert property (s_go(state_idle, event_start) ##0
    q.ch_flag[q.hreq_ch] != flag_comm |=> q.state == state_start_wait &&
    q.ch_flag[$past(q.hreq_ch)] == flag_comm && q.dev_flag[$past(q.hreq_dev)] == flag_comm
    && q.cmd_code == cmd_start ##3 l_q.cs2 == q.cmd_tog)
    else $error("start did not launch");
  a_addr_dir: assert property (disp_v && q.state == state_start_wait &&
    (disp_evt == event_addr || disp_evt == event_readdr) |=>
    q.state == ($past(q.hreq_data[IMPS_DIR_BIT]) ? state_read_addr_wait
                                                 : state_write_addr_wait))
    else $error("address wait state does not match direction");
  a_post_addr: assert property (s_go(state_write_addr_wait, event_addr_done) ##0
    q.tx_rem == IMPS_LEN_ZERO |=> q.state == state_stop_wait && q.cmd_code == cmd_stop)
    else $error("address-only write did not go to stop");
  a_send_next: assert property (s_go(state_send_wait, event_send_done) ##0
    q.tx_rem != IMPS_LEN_ZERO |=> q.need_tx && tx_ready && q.state == state_send_wait)
    else $error("send done did not request next byte");
  a_rx_nack: assert property (s_rx_last |=> q.cmd_code == cmd_receive && !q.cmd_ack)
    else $error("last byte not answered with NACK");
  a_rx_store: assert property (s_go(state_receive_wait, event_receive_done) |=>
    q.head_v && (q.tail_v ? q.tail_d : q.head_d) == $past(q.levt_data))
    else $error("received byte not stored");
  a_stop_release: assert property (s_go(state_stop_wait, event_stop) |=>
    q.state == state_idle && q.res_v && q.ch_flag[$past(q.cur_ch)] != flag_comm)
    else $error("stop did not release channel");
  a_arb_lost: assert property (disp_v && legal(q.state, disp_evt) &&
    disp_evt == event_arb_lost |=> q.state == state_idle && q.res_code == res_arb_lost)
    else $error("arbitration loss not handled");
  a_nack_stop: assert property (disp_v && legal(q.state, disp_evt) &&
    disp_evt == event_nack |=> q.state == state_stop_wait && q.nack_seen)
    else $error("NACK did not lead to stop");

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch_chk
    a_chan_indep: assert property (disp_v && q.cur_ch != c &&
      (disp_evt == event_stop || disp_evt == event_arb_lost) |=> $stable(q.ch_flag[c]))
      else $error("channel flag disturbed by another channel");
  end

endmodule : imps_sequencer

`default_nettype wire

// ===== shared/imps_pkg.sv
// Purpose: Shared types and constants for the I2C master protocol sequencer.
// Assumes: One sequencer; the bus engine reports its events with these codes.
// Notes:   Enumerations are in their natural order, so codes start at zero.
`default_nettype none

package imps_pkg;

  // Protocol states, coded 0 to 7 in this order.
  typedef enum logic [2:0] {
    state_uninitialized,
    state_idle,
    state_start_wait,
    state_write_addr_wait,
    state_read_addr_wait,
    state_send_wait,
    state_receive_wait,
    state_stop_wait
  } imps_state_t;

  // Events, coded 0 to 9; codes 0 to 3 are host requests, 4 to 9 engine reports.
  typedef enum logic [3:0] {
    event_init,
    event_start,
    event_addr,
    event_readdr,
    event_addr_done,
    event_send_done,
    event_receive_done,
    event_stop,
    event_arb_lost,
    event_nack
  } imps_event_t;

  // Per-channel and per-device communication state.
  typedef enum logic [1:0] {flag_idle, flag_finished, flag_nack, flag_comm} imps_flag_t;

  // Result reported to the requester.
  typedef enum logic [2:0] {
    res_ok, res_done, res_err_other, res_busy, res_nack, res_arb_lost, res_turn
  } imps_res_t;

  // Commands handed to the bus engine.
  typedef enum logic [2:0] {
    cmd_start, cmd_addr, cmd_readdr, cmd_send, cmd_receive, cmd_stop
  } imps_cmd_t;

  localparam int unsigned     IMPS_BYTE_W   = 8;
  localparam int unsigned     IMPS_LEN_W    = 8;
  localparam int unsigned     IMPS_DIR_BIT  = 0;     // Read/write bit of the address byte.
  localparam logic [7:0]      IMPS_LEN_ZERO = 8'h00;
  localparam logic [7:0]      IMPS_LEN_ONE  = 8'h01;
  localparam logic [7:0]      IMPS_LEN_TWO  = 8'h02;

endpackage : imps_pkg

`default_nettype wire

// ===== tb/imps_engine_model.sv
// Purpose: Behavioural bus engine standing beside the sequencer on the link clock.
// Assumes: One command is answered before the next arrives; replies come a byte time later.
// Notes:   Every command is logged so the bench can compare the order of bus operations.
`default_nettype none

module imps_engine_model
  import imps_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst_b,
  input  wire logic       eng_cmd_valid,
  input  wire imps_cmd_t  eng_cmd_code,
  input  wire logic [7:0] eng_cmd_data,
  input  wire logic       eng_cmd_ack,
  input  wire logic       nack_addr,
  output logic            eng_evt_valid,
  output logic [3:0]      eng_evt_code,
  output logic [7:0]      eng_evt_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] log_q [$];
  logic [5:0]  wait_q;
  logic [3:0]  pend_q;
  logic        busy_q;
  logic [7:0]  rx_byte_q;

  // Each command but start earns one report after a byte time; the data line wanders between.
  always @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      eng_evt_valid <= 1'b0;
      eng_evt_code  <= 4'h0;
      eng_evt_data  <= 8'h00;
      busy_q        <= 1'b0;
      wait_q        <= 6'h00;
      pend_q        <= 4'h0;
      rx_byte_q     <= 8'h50;
    end else begin
      eng_evt_valid <= 1'b0;
      eng_evt_data  <= ~eng_evt_data;
      if (eng_cmd_valid === 1'b1) begin
        log_q.push_back({eng_cmd_code == cmd_receive && eng_cmd_ack, eng_cmd_code,
                         eng_cmd_code == cmd_send ? eng_cmd_data : 8'h00});
        busy_q <= (eng_cmd_code != cmd_start);
        wait_q <= 6'h14;
        case (eng_cmd_code)
          cmd_addr, cmd_readdr: pend_q <= nack_addr ? event_nack : event_addr_done;
          cmd_send:             pend_q <= event_send_done;
          cmd_receive:          pend_q <= event_receive_done;
          default:              pend_q <= event_stop;
        endcase
      end else if (busy_q && wait_q == 6'h00) begin
        eng_evt_valid <= 1'b1;
        eng_evt_code  <= pend_q;
        eng_evt_data  <= rx_byte_q;
        busy_q        <= 1'b0;
        if (pend_q == event_receive_done) rx_byte_q <= rx_byte_q + 8'h01;
      end else if (busy_q) begin
        wait_q <= wait_q - 6'h01;
      end
    end
  end

endmodule : imps_engine_model

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the protocol sequencer with a behavioural engine.
// Assumes: Host inputs change on the falling edge of sys_clk; the engine runs on link_clk.
// Notes:   Repeated start and arbitration loss on the wire are not exercised here.
`default_nettype none

module tb_top
  import imps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, rst_b, link_clk, req_valid, req_ready, res_valid, tx_valid, tx_ready;
  logic rx_valid, rx_ready, eng_evt_valid, eng_cmd_valid, eng_cmd_ack, nack_addr, req_chan;
  logic [3:0]  req_event, eng_evt_code, channel_state_flag;
  logic [1:0]  req_dev;
  logic [7:0]  req_data, req_tx_len, req_rx_len, tx_data, rx_data, eng_evt_data;
  logic [7:0]  eng_cmd_data, device_state_flag;
  imps_res_t   res_code, res_last;
  imps_cmd_t   eng_cmd_code;
  imps_state_t seq_state;
  int          mismatches, comparisons, res_seen, mark;
  logic [7:0]  tx_q [$];
  logic [7:0]  rx_got [$];
  // Sequencer state and both flag words, packed for one-line checks.
  wire logic [14:0] st_all = {seq_state, channel_state_flag, device_state_flag};

  imps_sequencer #(.NUM_CH(2), .NUM_DEV(4)) i_imps_sequencer (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .req_valid(req_valid),
    .req_event(req_event), .req_chan(req_chan), .req_dev(req_dev), .req_data(req_data),
    .req_tx_len(req_tx_len), .req_rx_len(req_rx_len), .req_ready(req_ready),
    .res_valid(res_valid), .res_code(res_code), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .channel_state_flag(channel_state_flag), .device_state_flag(device_state_flag),
    .seq_state(seq_state), .eng_evt_valid(eng_evt_valid), .eng_evt_code(eng_evt_code),
    .eng_evt_data(eng_evt_data), .eng_cmd_valid(eng_cmd_valid), .eng_cmd_code(eng_cmd_code),
    .eng_cmd_data(eng_cmd_data), .eng_cmd_ack(eng_cmd_ack));

  imps_engine_model i_imps_engine_model (
    .link_clk(link_clk), .rst_b(rst_b), .eng_cmd_valid(eng_cmd_valid),
    .eng_cmd_code(eng_cmd_code), .eng_cmd_data(eng_cmd_data), .eng_cmd_ack(eng_cmd_ack),
    .nack_addr(nack_addr), .eng_evt_valid(eng_evt_valid), .eng_evt_code(eng_evt_code),
    .eng_evt_data(eng_evt_data));

  // The link clock is offset so its edges never line up with the system clock.
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // Results and read bytes are collected, and taken write bytes dropped from tx_q, on the sampling edge.
  always @(posedge sys_clk) begin
    if (res_valid === 1'b1) begin
      res_seen <= res_seen + 1;
      res_last <= res_code;
    end
    if (rx_valid === 1'b1 && rx_ready) rx_got.push_back(rx_data);
    if (tx_valid && tx_ready === 1'b1) void'(tx_q.pop_front());
  end

  // An empty write stream shows a changing pattern so stale data cannot pass as valid.
  always @(negedge sys_clk) begin
    tx_valid = (tx_q.size() > 0);
    tx_data  = (tx_q.size() > 0) ? tx_q[0] : ~tx_data;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_res(input imps_res_t exp);
    for (int k = 0; k < 3000 && res_seen == mark; k++) @(negedge sys_clk);
    check({res_seen != mark, res_last}, {1'b1, exp}, "result code");
    mark = res_seen;
  endtask : wait_res

  // The request is held until a rising edge finds the holder empty.
  task automatic send_req(input imps_event_t ev, input logic [7:0] adr, input logic [7:0] txl,
                          input logic [7:0] rxl, input logic ch, input logic [1:0] dv,
                          input imps_res_t exp);
    mark = res_seen;
    @(negedge sys_clk);
    req_valid = 1'b1;
    {req_event, req_data, req_tx_len, req_rx_len, req_chan, req_dev} = {ev, adr, txl, rxl, ch, dv};
    for (int k = 0; k < 100 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    wait_res(exp);
  endtask : send_req

  function automatic logic [11:0] op(input imps_cmd_t c, input logic ack, input logic [7:0] d);
    return {ack, c, d};
  endfunction : op

  task automatic check_log(input logic [11:0] exp [$]);
    check(i_imps_engine_model.log_q.size(), exp.size(), "command count");
    foreach (exp[i]) check(i_imps_engine_model.log_q[i], exp[i], "bus command");
    i_imps_engine_model.log_q.delete();
  endtask : check_log

  task automatic t_reset_init();
    check(st_all, 15'h0000, "reset values");
    send_req(event_addr, 8'ha0, 8'h00, 8'h00, 1'b0, 2'h0, res_err_other);
    check(seq_state, state_uninitialized, "state kept");
    send_req(event_init, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0, res_ok);
    check(seq_state, state_idle, "idle after init");
    send_req(event_stop, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0, res_err_other);
    send_req(event_addr, 8'ha0, 8'h00, 8'h00, 1'b0, 2'h0, res_err_other);
    check(seq_state, state_idle, "idle kept");
    $display("test reset and init done");
  endtask : t_reset_init

  task automatic t_write();
    tx_q = '{8'ha5, 8'h3c};
    send_req(event_start, 8'h00, 8'h02, 8'h00, 1'b1, 2'h2, res_ok);
    check(st_all, {state_start_wait, 12'hc30}, "flags");
    send_req(event_arb_lost, 8'h00, 8'h00, 8'h00, 1'b1, 2'h2, res_err_other);
    send_req(event_start, 8'h00, 8'h02, 8'h00, 1'b0, 2'h1, res_err_other);
    send_req(event_addr, 8'ha0, 8'h00, 8'h00, 1'b1, 2'h2, res_ok);
    check(seq_state, state_write_addr_wait, "write address wait");
    wait_res(res_done);
    repeat (2) @(negedge sys_clk);
    check(st_all, {state_idle, 12'h410}, "end");
    check_log('{op(cmd_start, 0, 0), op(cmd_addr, 0, 0), op(cmd_send, 0, 8'ha5),
                op(cmd_send, 0, 8'h3c), op(cmd_stop, 0, 0)});
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    rx_ready = 1'b0;
    send_req(event_start, 8'h00, 8'h00, 8'h03, 1'b0, 2'h1, res_ok);
    check(channel_state_flag, 4'h7, "channels independent");
    send_req(event_addr, 8'ha1, 8'h00, 8'h00, 1'b0, 2'h1, res_ok);
    check(seq_state, state_read_addr_wait, "read address wait");
    fork
      wait_res(res_done);
      begin
        repeat (400) @(negedge sys_clk);
        rx_ready = 1'b1;
      end
    join
    repeat (4) @(negedge sys_clk);
    check({8'(rx_got.size()), rx_got[0], rx_got[1], rx_got[2]}, {8'd3, 24'h505152}, "bytes");
    check({channel_state_flag, device_state_flag}, 12'h514, "flags after read");
    check_log('{op(cmd_start, 0, 0), op(cmd_addr, 0, 0), op(cmd_receive, 1, 0),
                op(cmd_receive, 1, 0), op(cmd_receive, 0, 0), op(cmd_stop, 0, 0)});
    $display("test read done");
  endtask : t_read

  task automatic t_nack();
    for (int k = 0; k < 2; k++) begin
      send_req(event_start, 8'h00, 8'h00, 8'h00, 1'b0, 2'h3, res_ok);
      send_req(event_addr, 8'ha0, 8'h00, 8'h00, 1'b0, 2'h3, res_ok);
      wait_res(k ? res_nack : res_done);
      check_log('{op(cmd_start, 0, 0), op(cmd_addr, 0, 0), op(cmd_stop, 0, 0)});
      nack_addr = 1'b1;
    end
    repeat (2) @(negedge sys_clk);
    check(st_all, {state_idle, 12'h694}, "nack");
    $display("test nack done");
  endtask : t_nack

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // The whole sequence needs a few microseconds; the watchdog leaves a wide margin.
  initial begin
    #100us;
    mismatches++;
    give_verdict();
  end

  initial begin
    {sys_clk, rst_b, req_valid, nack_addr, res_seen, mark} = '0;
    rx_ready = 1'b1;
    {req_event, req_data, req_tx_len, req_rx_len, req_chan, req_dev} = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_reset_init();
    t_write();
    t_read();
    t_nack();
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
